/* File: core/aac_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the alert limit block.
// Assumes: A 125 MHz system clock.
// Notes:   Included by the design and the bench; definitions only.
`ifndef AAC_DEFINES_SVH
`define AAC_DEFINES_SVH

`define AAC_PTR_RESULT       3'h0
`define AAC_PTR_STATUS       3'h1
`define AAC_PTR_CONFIG       3'h2
`define AAC_PTR_LOW          3'h3
`define AAC_PTR_HIGH         3'h4
`define AAC_PTR_HYST         3'h5
`define AAC_PTR_MIN          3'h6
`define AAC_PTR_MAX          3'h7

`define AAC_CFG_RESET        8'h00
`define AAC_CFG_RSVD_BIT     1
`define AAC_LOW_RESET        12'h000
`define AAC_HIGH_RESET       12'hFFF
`define AAC_HYST_RESET       12'h000
`define AAC_MIN_RESET        12'hFFF
`define AAC_FLAG_OVER        1
`define AAC_FLAG_UNDER       0
`define AAC_RESULT_FLAG_BIT  15

// Selector code 1 means 32 conversion times, so the shift is the code plus this offset.
`define AAC_INTERVAL_SHIFT   4'h4
`define AAC_SINGLE_CONV_TIME_NS 1000
`define AAC_CLK_PERIOD_NS    8
`define AAC_CONV_CYCLES      ((`AAC_SINGLE_CONV_TIME_NS + `AAC_CLK_PERIOD_NS - 1) / `AAC_CLK_PERIOD_NS)

// Bus address of the device; the value is arbitrary.
`define AAC_BUS_ADDR         7'h2A

`endif

/* File: core/aac_pkg.sv */
// Purpose: Types shared by the alert limit block.
// Assumes: Constants come from aac_defines.svh.
// Notes:   Configuration fields travel as one packed struct.
package aac_pkg;

    typedef struct packed {
        logic [2:0] cycle_time;
        logic       alert_hold;
        logic       flag_enable;
        logic       pin_enable;
        logic       reserved;
        logic       polarity;
    } aac_cfg_t;

    typedef enum logic [6:0] {
        AAC_IDLE = 7'h01,
        AAC_ADDR = 7'h02,
        AAC_AACK = 7'h04,
        AAC_WRX  = 7'h08,
        AAC_WACK = 7'h10,
        AAC_RTX  = 7'h20,
        AAC_RACK = 7'h40
    } aac_state_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  ptr;
        logic [7:0]  byte8;
        logic [11:0] word;
    } aac_wr_t;

endpackage

/* File: core/aac_alert_limit_regs.sv */
// Purpose: Pointer-addressed configuration, limit and tracking registers behind a two-wire slave.
// Assumes: Bus clock and data are asynchronous pins; conversion data arrives on sys_clk.
// Notes:   The converter itself sits outside; this block asks for conversions and checks results.
//
// Summary of operation
// RULE_01: Selector code zero keeps automatic conversion off.
// RULE_02: Any non-zero selector starts repeated conversions without bus traffic.
// RULE_03: Interval is conversion time times 32 up to 2048 for codes one to seven.
// RULE_04: Configuration resets to zero, so automatic mode is off after power-up.
// RULE_05: Hold clear: flags clear once result is back inside limit beyond hysteresis.
// RULE_06: Hold set: flags never self-clear, only a written one clears them.
// RULE_07: Flag enable gates bit 15 of the result word.
// RULE_08: Pin enable low floats the alert pin, high drives it.
// RULE_09: Polarity zero makes the alert pin active low, one active high.
// RULE_10: Configuration bit 1 reads zero; the master writes zero there.
// RULE_11: Result below the lower threshold raises a low alert; threshold resets to zero.
// RULE_12: Result above the upper threshold raises a high alert; threshold resets to all ones.
// RULE_13: Alert holds until result moves inside the limit by more than hysteresis.
// RULE_14: Bits 15 to 12 of the twelve-bit registers read zero; master writes zero.
// RULE_15: Those values are unsigned twelve-bit numbers in bits 11 to 0.
// RULE_16: Pointers 2 to 6 select configuration, limits, hysteresis and lowest result.
// RULE_17: Automatic mode replaces the stored lowest result only by a lower result.
// RULE_18: Writing 0FFFh restarts lowest tracking; it is also the reset value.
// RULE_19: Conversions outside automatic mode leave the lowest result alone.
// RULE_20: Over-range flag is bit 1, under-range flag is bit 0.
// RULE_21: Writing one to a status flag clears it whatever the hold bit.
// RULE_22: With flag enable set, bit 15 is high while either flag is set.
// RULE_23: First written byte loads the pointer; only its three low bits count.
// RULE_24: An enabled alert pin shows active level while either flag is set.
// RULE_25: A result equal to a threshold sets no flag.
`timescale 1ns/100ps
`include "aac_defines.svh"

module aac_alert_limit_regs
    import aac_pkg::*;
#(
    parameter logic [6:0]  BUS_ADDR    = `AAC_BUS_ADDR,
    parameter logic [23:0] CONV_CYCLES = 24'(`AAC_CONV_CYCLES)
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_data,
    output logic             conv_start,
    output logic             alert_o,
    output logic             alert_oe
);

    logic       rst_s1_n, rst_s2_n;
    logic       scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_n <= 1'b0;
            rst_s2_n <= 1'b0;
        end else begin
            rst_s1_n <= 1'b1;
            rst_s2_n <= rst_s1_n;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_s2_n) begin
        if (!rst_s2_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_p  <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_p  <= 1'b1;
        end else if (clk_en) begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            scl_p  <= scl_s2;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            sda_p  <= sda_s2;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_s2 & ~scl_p;
    assign scl_fall  = ~scl_s2 & scl_p;
    assign bus_start = scl_s2 & scl_p & sda_p & ~sda_s2;
    assign bus_stop  = scl_s2 & scl_p & ~sda_p & sda_s2;

    // Register state.
    aac_cfg_t    cfg_q, cfg_d;
    logic [11:0] low_q, low_d, high_q, high_d, hyst_q, hyst_d, min_q, min_d, res_q, res_d;
    logic [1:0]  flags_q, flags_d;
    logic [23:0] timer_q, timer_d;
    logic        conv_start_q, conv_start_d, alert_q, alert_d, alert_oe_q, alert_oe_d;

    // Slave state.
    aac_state_t  st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [7:0]  sh_q, sh_d, tx_q, tx_d, hi_q, hi_d;
    logic [2:0]  ptr_q, ptr_d;
    logic [1:0]  phase_q, phase_d;
    logic        drv_q, drv_d, rd_lo_q, rd_lo_d, rd_conv;
    aac_wr_t     wr;

    function automatic logic is_byte_reg(input logic [2:0] p);
        return (p == `AAC_PTR_STATUS) || (p == `AAC_PTR_CONFIG);
    endfunction

    function automatic logic [15:0] read_word(input logic [2:0] p);
        logic [15:0] w;
        w = 16'h0000;
        unique case (p)
            `AAC_PTR_RESULT: w = {cfg_q.flag_enable & (|flags_q), 3'h0, res_q}; // RULE_07 RULE_22
            `AAC_PTR_STATUS: w = {14'h0000, flags_q};
            `AAC_PTR_CONFIG: w = {8'h00, cfg_q.cycle_time, cfg_q.alert_hold, cfg_q.flag_enable,
                                  cfg_q.pin_enable, 1'b0, cfg_q.polarity}; // RULE_10
            `AAC_PTR_LOW:    w = {4'h0, low_q};  // RULE_14 RULE_15
            `AAC_PTR_HIGH:   w = {4'h0, high_q};
            `AAC_PTR_HYST:   w = {4'h0, hyst_q};
            `AAC_PTR_MIN:    w = {4'h0, min_q};
            `AAC_PTR_MAX:    w = 16'h0000;
        endcase
        return w;
    endfunction

    // The first byte of a sixteen-bit register is its high byte; byte registers repeat.
    function automatic logic [7:0] pick_byte(input logic [2:0] p, input logic lo);
        logic [15:0] w;
        w = read_word(p);
        return (lo || is_byte_reg(p)) ? w[7:0] : w[15:8];
    endfunction

    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        tx_d    = tx_q;
        hi_d    = hi_q;
        ptr_d   = ptr_q;
        phase_d = phase_q;
        drv_d   = drv_q;
        rd_lo_d = rd_lo_q;
        rd_conv = 1'b0;
        wr      = '0;
        if (bus_stop) begin
            st_d  = AAC_IDLE;
            drv_d = 1'b0;
        end else if (bus_start) begin
            st_d  = AAC_ADDR;
            cnt_d = 4'h0;
            drv_d = 1'b0;
        end else begin
            unique case (st_q)
                AAC_IDLE: begin
                    drv_d = 1'b0;
                end
                AAC_ADDR: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_s2};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        if (sh_q[7:1] == BUS_ADDR) begin
                            st_d    = AAC_AACK;
                            drv_d   = 1'b1;
                            phase_d = 2'h0;
                            tx_d    = pick_byte(ptr_q, 1'b0);
                            rd_lo_d = ~is_byte_reg(ptr_q);
                            // A read of the result word asks for a fresh conversion.
                            rd_conv = sh_q[0] && ptr_q == `AAC_PTR_RESULT;
                        end else begin
                            st_d = AAC_IDLE;
                        end
                    end
                end
                AAC_AACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (sh_q[0]) begin
                            st_d  = AAC_RTX;
                            drv_d = ~tx_q[7];
                        end else begin
                            st_d  = AAC_WRX;
                            drv_d = 1'b0;
                        end
                    end
                end
                AAC_WRX: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_s2};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        st_d  = AAC_WACK;
                        drv_d = 1'b1;
                        if (phase_q == 2'h0) begin
                            ptr_d   = sh_q[2:0]; // RULE_23
                            phase_d = 2'h1;
                        end else if (is_byte_reg(ptr_q)) begin
                            wr.valid = 1'b1;
                            wr.ptr   = ptr_q;
                            wr.byte8 = sh_q;
                        end else if (phase_q == 2'h1) begin
                            hi_d    = sh_q;
                            phase_d = 2'h2;
                        end else begin
                            wr.valid = 1'b1;
                            wr.ptr   = ptr_q;
                            wr.word  = {hi_q[3:0], sh_q}; // RULE_14 RULE_15
                            phase_d  = 2'h1;
                        end
                    end
                end
                AAC_WACK: begin
                    if (scl_fall) begin
                        st_d  = AAC_WRX;
                        cnt_d = 4'h0;
                        drv_d = 1'b0;
                    end
                end
                AAC_RTX: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == 4'h8) begin
                            st_d  = AAC_RACK;
                            drv_d = 1'b0;
                        end else begin
                            tx_d  = {tx_q[6:0], 1'b0};
                            drv_d = ~tx_q[6];
                        end
                    end
                end
                AAC_RACK: begin
                    if (scl_rise) begin
                        if (sda_s2) begin
                            st_d = AAC_IDLE;
                        end else if (rd_lo_q) begin
                            tx_d    = pick_byte(ptr_q, 1'b1);
                            rd_lo_d = 1'b0;
                        end else begin
                            tx_d    = pick_byte(ptr_q, 1'b0);
                            rd_lo_d = ~is_byte_reg(ptr_q);
                        end
                    end else if (scl_fall) begin
                        st_d  = AAC_RTX;
                        cnt_d = 4'h0;
                        drv_d = ~tx_q[7];
                    end
                end
            endcase
        end
    end

    logic over_hit, under_hit, over_back, under_back, auto_on, auto_tick;
    logic [1:0] flag_set, flag_clr;

    always_comb begin
        cfg_d      = cfg_q;
        low_d      = low_q;
        high_d     = high_q;
        hyst_d     = hyst_q;
        min_d      = min_q;
        res_d      = res_q;
        timer_d    = timer_q;
        auto_on    = cfg_q.cycle_time != 3'h0; // RULE_01 RULE_02
        auto_tick  = 1'b0;
        // Thirteen-bit sums keep the hysteresis window from wrapping at the code range ends.
        over_hit   = conv_data > high_q; // RULE_12 RULE_25
        under_hit  = conv_data < low_q;  // RULE_11 RULE_25
        over_back  = {1'b0, conv_data} + {1'b0, hyst_q} < {1'b0, high_q}; // RULE_13
        under_back = {1'b0, conv_data} > {1'b0, low_q} + {1'b0, hyst_q};  // RULE_13
        flag_set   = 2'h0;
        flag_clr   = 2'h0;
        if (conv_done) begin
            res_d = conv_data;
            flag_set[`AAC_FLAG_OVER]  = over_hit;  // RULE_20
            flag_set[`AAC_FLAG_UNDER] = under_hit; // RULE_20
            if (!cfg_q.alert_hold) begin
                flag_clr[`AAC_FLAG_OVER]  = over_back;  // RULE_05
                flag_clr[`AAC_FLAG_UNDER] = under_back; // RULE_05 RULE_06
            end
            if (auto_on && conv_data < min_q) begin
                min_d = conv_data; // RULE_17 RULE_19
            end
        end
        if (wr.valid) begin
            unique case (wr.ptr)
                `AAC_PTR_STATUS: flag_clr = flag_clr | wr.byte8[1:0]; // RULE_21 RULE_06
                `AAC_PTR_CONFIG: begin
                    cfg_d          = aac_cfg_t'(wr.byte8);
                    cfg_d.reserved = 1'b0; // RULE_10
                end
                `AAC_PTR_LOW:    low_d  = wr.word; // RULE_16
                `AAC_PTR_HIGH:   high_d = wr.word; // RULE_16
                `AAC_PTR_HYST:   hyst_d = wr.word; // RULE_16
                `AAC_PTR_MIN:    min_d  = wr.word; // RULE_18
                default:         ;
            endcase
        end
        // A new violation wins over a clear that lands in the same cycle.
        flags_d = (flags_q & ~flag_clr) | flag_set;
        if (!auto_on) begin
            timer_d = 24'h000000; // RULE_01
        end else if (timer_q == 24'h000000) begin
            auto_tick = 1'b1; // RULE_02
            timer_d   = (CONV_CYCLES << (cfg_q.cycle_time + `AAC_INTERVAL_SHIFT)) - 24'h000001; // RULE_03
        end else begin
            timer_d = timer_q - 24'h000001;
        end
        conv_start_d = auto_tick | rd_conv;
        alert_d      = cfg_q.polarity ? (|flags_q) : ~(|flags_q); // RULE_09 RULE_24
        alert_oe_d   = cfg_q.pin_enable; // RULE_08
    end

    always_ff @(posedge sys_clk or negedge rst_s2_n) begin
        if (!rst_s2_n) begin
            cfg_q        <= aac_cfg_t'(`AAC_CFG_RESET); // RULE_04
            low_q        <= `AAC_LOW_RESET;  // RULE_11
            high_q       <= `AAC_HIGH_RESET; // RULE_12
            hyst_q       <= `AAC_HYST_RESET; // RULE_13
            min_q        <= `AAC_MIN_RESET;  // RULE_18
            res_q        <= 12'h000;
            flags_q      <= 2'h0;
            timer_q      <= 24'h000000;
            conv_start_q <= 1'b0;
            alert_q      <= 1'b1;
            alert_oe_q   <= 1'b0;
            st_q         <= AAC_IDLE;
            cnt_q        <= 4'h0;
            sh_q         <= 8'h00;
            tx_q         <= 8'h00;
            hi_q         <= 8'h00;
            ptr_q        <= `AAC_PTR_RESULT;
            phase_q      <= 2'h0;
            drv_q        <= 1'b0;
            rd_lo_q      <= 1'b0;
        end else if (clk_en) begin
            cfg_q        <= cfg_d;
            low_q        <= low_d;
            high_q       <= high_d;
            hyst_q       <= hyst_d;
            min_q        <= min_d;
            res_q        <= res_d;
            flags_q      <= flags_d;
            timer_q      <= timer_d;
            conv_start_q <= conv_start_d;
            alert_q      <= alert_d;
            alert_oe_q   <= alert_oe_d;
            st_q         <= st_d;
            cnt_q        <= cnt_d;
            sh_q         <= sh_d;
            tx_q         <= tx_d;
            hi_q         <= hi_d;
            ptr_q        <= ptr_d;
            phase_q      <= phase_d;
            drv_q        <= drv_d;
            rd_lo_q      <= rd_lo_d;
        end
    end

    // The data line is open drain: only a low is ever driven.
    assign sda_o      = 1'b0;
    assign sda_oe     = drv_q;
    assign conv_start = conv_start_q;
    assign alert_o    = alert_q;
    assign alert_oe   = alert_oe_q;

endmodule // aac_alert_limit_regs

/* File: verification/aac_alert_limit_regs_sva.sv */
// Purpose: Port-level checks of the alert limit register block.
// Assumes: Bus lines idle high; the converter answers outside bus frames.
// Notes:   Bound to every instance of the block.
`timescale 1ns/100ps

module aac_alert_limit_regs_sva #(
    parameter logic [23:0] CONV_CYCLES = 24'h2
) (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        scl_i,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe,
    input wire logic        conv_done,
    input wire logic [11:0] conv_data,
    input wire logic        conv_start,
    input wire logic        alert_o,
    input wire logic        alert_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic [15:0] gap_q;
    logic [15:0] gap_d;

    // Saturates so that a long quiet spell never wraps into a short gap.
    always_comb begin
        gap_d = gap_q;
        if (conv_start) gap_d = 16'h0001;
        else if (gap_q != 16'hFFFF) gap_d = gap_q + 16'h0001;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) gap_q <= 16'hFFFF;
        else gap_q <= gap_d;
    end

    sequence bus_idle4;
        (scl_i && sda_i)[*4];
    endsequence

    sequence quiet6;
        (scl_i && sda_i && !conv_done)[*6];
    endsequence

    AST_SDA_OPEN_DRAIN:
        assert property (sda_o == 1'b0) else $error("data pin driven high");
    AST_RESET_QUIET:
        assert property ($rose(rst_n) |-> !sda_oe && !conv_start && !alert_oe)
        else $error("outputs active at reset release");
    AST_AUTO_OFF_AFTER_RESET:
        assert property ($rose(rst_n) |-> !conv_start[*8])
        else $error("conversion requested right after reset");
    AST_CONV_PULSE:
        assert property (conv_start |=> !conv_start) else $error("conversion request too long");
    AST_AUTO_SPACING:
        assert property (bus_idle4 ##0 conv_start |-> gap_q >= 16'(CONV_CYCLES << 5))
        else $error("automatic conversions too close");
    AST_ALERT_QUIET:
        assert property (quiet6 |=> $stable(alert_o) && $stable(alert_oe))
        else $error("alert pin moved without cause");
    AST_ALERT_LATENCY:
        assert property (bus_idle4 ##0 $changed(alert_o) |-> $past(conv_done, 2))
        else $error("alert pin moved at wrong time");
    AST_SDA_STANDS:
        assert property ($rose(sda_oe) |-> sda_oe[*8]) else $error("data pull too short");
    AST_SDA_MOVES_LOW:
        assert property ($changed(sda_oe) |-> !scl_i) else $error("data moved with clock high");
endmodule // aac_alert_limit_regs_sva

bind aac_alert_limit_regs aac_alert_limit_regs_sva #(.CONV_CYCLES(CONV_CYCLES)) i_sva (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .conv_done(conv_done), .conv_data(conv_data),
    .conv_start(conv_start), .alert_o(alert_o), .alert_oe(alert_oe));

/* File: verification/aac_bus_master.sv */
// Purpose: Two-wire bus master driving the clock and data pins of the block.
// Assumes: Pull-ups on both lines; each clock phase lasts five system clocks.
// Notes:   The bench calls the tasks hierarchically; the clock stands high between frames.
`timescale 1ns/100ps

module aac_bus_master (
    input  wire logic sys_clk,
    input  wire logic sda_oe,
    output logic      scl_i,
    output logic      sda_i
);
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;

    // The pull-up wins whenever neither side pulls data low.
    assign sda_i = sda_q & ~sda_oe;
    assign scl_i = scl_q;

    task automatic ph;
        repeat (5) @(posedge sys_clk);
    endtask

    task automatic start;
        sda_q <= 1'b1;
        ph;
        scl_q <= 1'b1;
        ph;
        sda_q <= 1'b0;
        ph;
        scl_q <= 1'b0;
        ph;
    endtask

    task automatic bitx(input logic b, output logic r);
        repeat (4) @(posedge sys_clk);
        sda_q <= b;
        @(posedge sys_clk);
        scl_q <= 1'b1;
        ph;
        r = sda_i;
        scl_q <= 1'b0;
    endtask

    task automatic xfer(input logic [7:0] w, input logic mack, output logic [7:0] r,
                        output logic ack);
        for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
        bitx(mack, ack);
    endtask

    task automatic stop;
        sda_q <= 1'b0;
        ph;
        scl_q <= 1'b1;
        ph;
        sda_q <= 1'b1;
        ph;
    endtask
endmodule // aac_bus_master

/* File: verification/aac_alert_limit_regs_tb_top.sv */
// Purpose: Self-checking bench of the alert limit register block.
// Assumes: The converter is played by the bench; reads of the result get no answer.
// Notes:   The conversion time parameter is cut to two clocks to keep intervals short.
`timescale 1ns/100ps
`include "aac_defines.svh"

module aac_alert_limit_regs_tb_top;
    localparam logic [23:0] CONV_CYC = 24'h000002;
    localparam logic [7:0]  ADDR_W   = {`AAC_BUS_ADDR, 1'b0};

    typedef struct packed {
        logic [7:0]  wp;
        logic [7:0]  rp;
        logic [15:0] wv;
        logic [15:0] ev;
        logic [1:0]  n;
    } aac_row_t;

    logic        sys_clk = 1'b0;
    logic        rst_n;
    logic        conv_done;
    logic [11:0] conv_data;
    logic        scl_i, sda_i, sda_o, sda_oe, conv_start, alert_o, alert_oe;
    int          failures;
    int          checks;
    aac_row_t    rows [10] = '{
        '{8'h02, 8'h02, 16'h00FF, 16'h00FD, 2'h1},
        '{8'h02, 8'h02, 16'h001D, 16'h001D, 2'h1},
        '{8'h03, 8'h03, 16'hF123, 16'h0123, 2'h2},
        '{8'h04, 8'h04, 16'hFABC, 16'h0ABC, 2'h2},
        '{8'h05, 8'h05, 16'hF805, 16'h0805, 2'h2},
        '{8'h06, 8'h06, 16'hF456, 16'h0456, 2'h2},
        '{8'h06, 8'h06, 16'h0FFF, 16'h0FFF, 2'h2},
        '{8'h0B, 8'h03, 16'h0456, 16'h0456, 2'h2},
        '{8'h07, 8'h07, 16'h0123, 16'h0000, 2'h2},
        '{8'h02, 8'h02, 16'h0000, 16'h0000, 2'h1}};

    always #4 sys_clk = ~sys_clk;

    aac_alert_limit_regs #(.CONV_CYCLES(CONV_CYC)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .scl_i(scl_i), .sda_i(sda_i),
        .sda_o(sda_o), .sda_oe(sda_oe), .conv_done(conv_done), .conv_data(conv_data),
        .conv_start(conv_start), .alert_o(alert_o), .alert_oe(alert_oe));

    aac_bus_master i_bus (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl_i(scl_i), .sda_i(sda_i));

    task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic cmp1(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] p, input logic [15:0] v, input logic [1:0] n);
        logic [7:0] r;
        logic       a0, a1, a2, a3;
        i_bus.start;
        i_bus.xfer(ADDR_W, 1'b1, r, a0);
        i_bus.xfer(p, 1'b1, r, a1);
        a2 = 1'b0;
        if (n == 2'h2) i_bus.xfer(v[15:8], 1'b1, r, a2);
        i_bus.xfer(v[7:0], 1'b1, r, a3);
        i_bus.stop;
        cmp1(a0 | a1 | a2 | a3, 1'b0);
    endtask

    task automatic chk(input logic [7:0] p, input logic [1:0] n, input logic [15:0] e);
        logic [7:0] hi, lo;
        logic       a;
        i_bus.start;
        i_bus.xfer(ADDR_W, 1'b1, hi, a);
        i_bus.xfer(p, 1'b1, hi, a);
        i_bus.start;
        i_bus.xfer(ADDR_W | 8'h01, 1'b1, hi, a);
        hi = 8'h00;
        if (n == 2'h2) i_bus.xfer(8'hFF, 1'b0, hi, a);
        i_bus.xfer(8'hFF, 1'b1, lo, a);
        i_bus.stop;
        cmp16({hi, lo}, e);
    endtask

    task automatic conv(input logic [11:0] d);
        conv_done <= 1'b1;
        conv_data <= d;
        @(posedge sys_clk);
        conv_done <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    // Measures from one request to the next, starting at the first request after the write frame ends.
    task automatic gap(output int n);
        int k;
        k = 0;
        while (conv_start !== 1'b1 && k < 5000) begin
            @(posedge sys_clk);
            k++;
        end
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (conv_start !== 1'b1 && n < 5000);
    endtask

    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #600_000;
        failures++;
        wrap_up;
    end

    initial begin
        logic [7:0]  r8;
        logic        a;
        int          n;
        static logic [15:0] rv [5] = '{16'h0000, 16'h0000, 16'h0FFF, 16'h0000, 16'h0FFF};
        failures = 0;
        checks = 0;
        rst_n = 1'b0;
        conv_done = 1'b0;
        conv_data = 12'h000;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        foreach (rows[i]) begin
            wr(rows[i].wp, rows[i].wv, rows[i].n);
            chk(rows[i].rp, rows[i].n, rows[i].ev);
        end
        i_bus.start;
        i_bus.xfer(ADDR_W ^ 8'h02, 1'b1, r8, a);
        i_bus.stop;
        cmp1(a, 1'b1);
        $display("test table done");
        wr(8'h03, 16'h0100, 2'h2);
        wr(8'h04, 16'h0200, 2'h2);
        wr(8'h05, 16'h0010, 2'h2);
        wr(8'h02, 16'h000D, 2'h1);
        conv(12'h200);
        chk(8'h01, 2'h1, 16'h0000);
        conv(12'h201);
        chk(8'h01, 2'h1, 16'h0002);
        cmp1(alert_o, 1'b1);
        cmp1(alert_oe, 1'b1);
        chk(8'h00, 2'h2, 16'h8201);
        conv(12'h1F5);
        chk(8'h01, 2'h1, 16'h0002);
        conv(12'h1EF);
        chk(8'h01, 2'h1, 16'h0000);
        cmp1(alert_o, 1'b0);
        conv(12'h0FF);
        chk(8'h01, 2'h1, 16'h0001);
        wr(8'h02, 16'h000C, 2'h1);
        cmp1(alert_o, 1'b0);
        wr(8'h02, 16'h0008, 2'h1);
        cmp1(alert_oe, 1'b0);
        wr(8'h01, 16'h0001, 2'h1);
        chk(8'h01, 2'h1, 16'h0000);
        wr(8'h02, 16'h0010, 2'h1);
        conv(12'h0FF);
        conv(12'h150);
        chk(8'h01, 2'h1, 16'h0001);
        chk(8'h00, 2'h2, 16'h0150);
        wr(8'h01, 16'h0001, 2'h1);
        chk(8'h01, 2'h1, 16'h0000);
        $display("test flags done");
        for (int c = 1; c < 8; c++) begin
            wr(8'h02, {8'h00, 3'(c), 5'h00}, 2'h1);
            gap(n);
            cmp16(16'(n), 16'(CONV_CYC << (c + 4)));
        end
        conv(12'h080);
        conv(12'h090);
        chk(8'h06, 2'h2, 16'h0080);
        wr(8'h02, 16'h0000, 2'h1);
        n = 0;
        repeat (300) begin
            @(posedge sys_clk);
            if (conv_start === 1'b1) n++;
        end
        cmp16(16'(n), 16'h0000);
        conv(12'h010);
        chk(8'h06, 2'h2, 16'h0080);
        $display("test auto done");
        rst_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        cmp1(alert_oe, 1'b0);
        for (int p = 2; p < 7; p++) begin
            chk(8'(p), (p < 3) ? 2'h1 : 2'h2, rv[p-2]);
        end
        $display("test reset done");
        wrap_up;
    end
endmodule // aac_alert_limit_regs_tb_top
